// [hdl/rtc_ctrl_pkg.sv]
// Package for the clock control register logic.
// Assumes a single processor clock and an 8-bit register pair interface.
package rtc_ctrl_pkg;
    // Indirect address register fields
    localparam int ADR_BUSY_BIT     = 7;
    localparam int ADR_AUTORD_BIT   = 6;
    localparam int ADR_SHORT_BIT    = 4;
    localparam int ADR_FIELD_MSB    = 3;
    localparam logic [7:0] ADR_WMASK = 8'h5f;
    localparam logic [7:0] ADR_RESET = 8'h00;
    localparam logic [7:0] DAT_RESET = 8'h00;
    // Internal address of the control register
    localparam logic [3:0] CTRL_IADDR = 4'h4;
    // Control register fields
    localparam int CTL_OSC_EN_BIT   = 7;
    localparam int CTL_DET_EN_BIT   = 6;
    localparam int CTL_FAIL_BIT     = 5;
    localparam int CTL_RUN_BIT      = 4;
    localparam int CTL_AEN_BIT      = 3;
    localparam int CTL_ALARM_BIT    = 2;
    localparam int CTL_SET_BIT      = 1;
    localparam int CTL_CAP_BIT      = 0;
    localparam logic CTL_BIT_RESET  = 1'b0;
    // Synchroniser depth for slow-domain signals
    localparam int SYNC_STAGES      = 2;
endpackage

// [hdl/rtc_control_register_logic.sv]
// Control and status register of the low-power clock, reached indirectly.
// Assumes slow-domain inputs arrive as levels and are resynchronised here.
//
// Function
// - Oscillator and bias enables follow the oscillator enable bit.
// - The missing-oscillator detector runs only while enabled.
// - A detector timeout sets the fail flag; software clears it.
// - The timer runs while the run bit is 1 and holds otherwise.
// - Alarm compare works only when enabled; a write clears the flag.
// - Reading the alarm bit returns the alarm event flag itself.
// - Writing the alarm bit sets auto reset, not the flag.
// - Writing 1 to the set bit starts a set, cleared when done.
// - Writing 1 to the capture bit starts a capture, cleared when done.
// - The alarm flag stays high for at most one oscillator cycle.
// - The control register lives only at internal address 0x04.
// - After reset all control bits are 0 but the fail flag varies.
// - The four-bit address field selects the register transferred.
// - Writing 1 to busy fetches the selected register as data.
`timescale 1ns/100ps
module rtc_control_register_logic
    import rtc_ctrl_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       addr_wr_en,
    input  wire logic       data_wr_en,
    input  wire logic       data_rd_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] addr_rdata,
    output logic      [7:0] data_rdata,
    input  wire logic       osc_clk_in,
    input  wire logic       osc_timeout,
    input  wire logic       alarm_match,
    input  wire logic       fail_at_reset,
    output logic            osc_enable,
    output logic            osc_bias_en,
    output logic            missing_osc_detect_en,
    output logic            timer_run,
    output logic            alarm_enable,
    output logic            alarm_autoreset_en,
    output logic            timer_set_strobe,
    output logic            timer_capture_strobe,
    output logic            timer_autoreset_strobe
);
    // Slow-domain synchronisers: lane 0 oscillator, 1 timeout, 2 match
    logic [2:0] slow_in;
    logic [2:0] slow_rise;
    logic       osc_rise, tmo_rise, match_rise;

    assign slow_in = {alarm_match, osc_timeout, osc_clk_in};

    for (genvar i = 0; i < 3; i++)
    begin : g_sync
        logic [SYNC_STAGES-1:0] sync_q, sync_d;
        logic                   last_q, last_d;
        always_comb
        begin
            sync_d = {sync_q[SYNC_STAGES-2:0], slow_in[i]};
            last_d = sync_q[SYNC_STAGES-1];
        end
        always_ff @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                sync_q <= '0;
                last_q <= 1'b0;
            end
            else
            begin
                sync_q <= sync_d;
                last_q <= last_d;
            end
        end
        assign slow_rise[i] = sync_q[SYNC_STAGES-1] & ~last_q;
    end

    assign osc_rise   = slow_rise[0];
    assign tmo_rise   = slow_rise[1];
    assign match_rise = slow_rise[2];

    // Register state
    logic [7:0] adr_q,   adr_d;
    logic [7:0] dat_q,   dat_d;
    logic       osc_en_q, osc_en_d;
    logic       det_en_q, det_en_d;
    logic       fail_q,   fail_d;
    logic       run_q,    run_d;
    logic       aen_q,    aen_d;
    logic       auto_q,   auto_d;
    logic       flag_q,   flag_d;
    logic       set_q,    set_d;
    logic       cap_q,    cap_d;
    logic       init_q,   init_d;
    logic       set_stb_q, set_stb_d;
    logic       cap_stb_q, cap_stb_d;
    logic       ar_stb_q,  ar_stb_d;
    logic [7:0] ctrl_image;
    logic       ctrl_sel;
    logic       ctrl_wr;
    logic       alarm_set;
    logic       fail_set;

    assign ctrl_sel = (adr_q[ADR_FIELD_MSB:0] == CTRL_IADDR);
    assign ctrl_wr  = data_wr_en & ctrl_sel;
    assign alarm_set = aen_q & match_rise;
    assign fail_set  = det_en_q & osc_en_q & tmo_rise;

    assign ctrl_image = {osc_en_q, det_en_q, fail_q, run_q,
                         aen_q, flag_q, set_q, cap_q};

    always_comb
    begin
        adr_d     = adr_q;
        dat_d     = dat_q;
        osc_en_d  = osc_en_q;
        det_en_d  = det_en_q;
        fail_d    = fail_q;
        run_d     = run_q;
        aen_d     = aen_q;
        auto_d    = auto_q;
        flag_d    = flag_q;
        set_d     = set_q;
        cap_d     = cap_q;
        init_d    = 1'b1;
        set_stb_d = 1'b0;
        cap_stb_d = 1'b0;
        ar_stb_d  = 1'b0;
        // Fetch completes one cycle after busy goes high
        if (adr_q[ADR_BUSY_BIT])
        begin
            adr_d[ADR_BUSY_BIT] = 1'b0;
            dat_d = ctrl_sel ? ctrl_image : 8'h00;
        end
        if (addr_wr_en)
        begin
            adr_d = wdata & ADR_WMASK;
            adr_d[ADR_BUSY_BIT] = wdata[ADR_BUSY_BIT];
        end
        else if (data_rd_en && adr_q[ADR_AUTORD_BIT])
            adr_d[ADR_BUSY_BIT] = 1'b1;
        if (data_wr_en)
            dat_d = wdata;
        // Oscillator cycle ends any pending alarm flag
        if (osc_rise)
            flag_d = 1'b0;
        if (set_q && osc_rise)
        begin
            set_d     = 1'b0;
            set_stb_d = 1'b1;
        end
        if (cap_q && osc_rise)
        begin
            cap_d     = 1'b0;
            cap_stb_d = 1'b1;
        end
        if (ctrl_wr)
        begin
            osc_en_d = wdata[CTL_OSC_EN_BIT];
            det_en_d = wdata[CTL_DET_EN_BIT];
            run_d    = wdata[CTL_RUN_BIT];
            aen_d    = wdata[CTL_AEN_BIT];
            auto_d   = wdata[CTL_ALARM_BIT];
            flag_d   = 1'b0;
            fail_d   = fail_d & wdata[CTL_FAIL_BIT];
            set_d    = set_d | wdata[CTL_SET_BIT];
            cap_d    = cap_d | wdata[CTL_CAP_BIT];
        end
        // Hardware set wins over any clear
        if (alarm_set)
        begin
            flag_d   = 1'b1;
            ar_stb_d = auto_q;
        end
        if (fail_set)
            fail_d = 1'b1;
        if (!init_q)
            fail_d = fail_at_reset;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adr_q     <= ADR_RESET;
            dat_q     <= DAT_RESET;
            osc_en_q  <= CTL_BIT_RESET;
            det_en_q  <= CTL_BIT_RESET;
            fail_q    <= CTL_BIT_RESET;
            run_q     <= CTL_BIT_RESET;
            aen_q     <= CTL_BIT_RESET;
            auto_q    <= CTL_BIT_RESET;
            flag_q    <= CTL_BIT_RESET;
            set_q     <= CTL_BIT_RESET;
            cap_q     <= CTL_BIT_RESET;
            init_q    <= 1'b0;
            set_stb_q <= 1'b0;
            cap_stb_q <= 1'b0;
            ar_stb_q  <= 1'b0;
        end
        else
        begin
            adr_q     <= adr_d;
            dat_q     <= dat_d;
            osc_en_q  <= osc_en_d;
            det_en_q  <= det_en_d;
            fail_q    <= fail_d;
            run_q     <= run_d;
            aen_q     <= aen_d;
            auto_q    <= auto_d;
            flag_q    <= flag_d;
            set_q     <= set_d;
            cap_q     <= cap_d;
            init_q    <= init_d;
            set_stb_q <= set_stb_d;
            cap_stb_q <= cap_stb_d;
            ar_stb_q  <= ar_stb_d;
        end
    end

    assign addr_rdata             = adr_q;
    assign data_rdata             = dat_q;
    assign osc_enable             = osc_en_q;
    assign osc_bias_en            = osc_en_q;
    assign missing_osc_detect_en  = det_en_q & osc_en_q;
    assign timer_run              = run_q;
    assign alarm_enable           = aen_q;
    assign alarm_autoreset_en     = auto_q;
    assign timer_set_strobe       = set_stb_q;
    assign timer_capture_strobe   = cap_stb_q;
    assign timer_autoreset_strobe = ar_stb_q;

    // Checks
    logic [1:0] flag_rises_q;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_rises_q <= 2'h0;
        else if (!flag_q)
            flag_rises_q <= 2'h0;
        else if (osc_rise && flag_rises_q != 2'h3)
            flag_rises_q <= flag_rises_q + 2'h1;
    end

    sequence s_busy_write;
        addr_wr_en && wdata[ADR_BUSY_BIT];
    endsequence
    sequence s_fetch_done;
        !adr_q[ADR_BUSY_BIT];
    endsequence

    property p_fetch;
        @(posedge core_clk) disable iff (!rst_n)
        s_busy_write ##1 (!addr_wr_en && !data_wr_en && ctrl_sel) |=>
            s_fetch_done and (data_rdata == $past(ctrl_image));
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("indirect fetch did not load control image");

    property p_run_follows;
        @(posedge core_clk) disable iff (!rst_n)
        ctrl_wr |=> timer_run == $past(wdata[CTL_RUN_BIT]);
    endproperty
    a_run_follows: assert property (p_run_follows)
        else $error("run bit not taken from write");

    property p_osc_en;
        @(posedge core_clk) disable iff (!rst_n)
        ctrl_wr |=> osc_enable == $past(wdata[CTL_OSC_EN_BIT])
            && osc_bias_en == osc_enable;
    endproperty
    a_osc_en: assert property (p_osc_en)
        else $error("oscillator enable wrong after write");

    property p_fail_set;
        @(posedge core_clk) disable iff (!rst_n)
        init_q && fail_set |=> ctrl_image[CTL_FAIL_BIT];
    endproperty
    a_fail_set: assert property (p_fail_set)
        else $error("timeout did not set fail flag");

    property p_fail_hold;
        @(posedge core_clk) disable iff (!rst_n)
        init_q && fail_q && !ctrl_wr |=> fail_q;
    endproperty
    a_fail_hold: assert property (p_fail_hold)
        else $error("fail flag dropped without a write");

    property p_det_gate;
        @(posedge core_clk) disable iff (!rst_n)
        !det_en_q && init_q && !ctrl_wr && !fail_q |=> !fail_q;
    endproperty
    a_det_gate: assert property (p_det_gate)
        else $error("fail flag set with detector off");

    property p_flag_short;
        @(posedge core_clk) disable iff (!rst_n)
        flag_q |-> flag_rises_q < 2'h2;
    endproperty
    a_flag_short: assert property (p_flag_short)
        else $error("alarm flag outlived an oscillator cycle");

    property p_aen_clear;
        @(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && !alarm_set |=> !flag_q;
    endproperty
    a_aen_clear: assert property (p_aen_clear)
        else $error("control write left alarm flag set");

    property p_no_alarm_off;
        @(posedge core_clk) disable iff (!rst_n)
        !aen_q |=> !$rose(flag_q);
    endproperty
    a_no_alarm_off: assert property (p_no_alarm_off)
        else $error("alarm flag rose while disabled");

    property p_set_done;
        @(posedge core_clk) disable iff (!rst_n)
        set_q && osc_rise && !ctrl_wr |=> !set_q && timer_set_strobe;
    endproperty
    a_set_done: assert property (p_set_done)
        else $error("set request not completed on oscillator edge");

    property p_cap_done;
        @(posedge core_clk) disable iff (!rst_n)
        cap_q && osc_rise && !ctrl_wr |=> !cap_q && timer_capture_strobe;
    endproperty
    a_cap_done: assert property (p_cap_done)
        else $error("capture request not completed");

    property p_sel_only;
        @(posedge core_clk) disable iff (!rst_n)
        data_wr_en && !ctrl_sel |=> $stable(ctrl_image[CTL_RUN_BIT]);
    endproperty
    a_sel_only: assert property (p_sel_only)
        else $error("control changed by write to other address");

endmodule // rtc_control_register_logic

// [tb/rtc_control_register_logic_tb.sv]
// Self-checking bench for the clock control register logic.
// Assumes one core clock, async active-low reset, bench drives all ports.
`timescale 1ns/100ps
module rtc_control_register_logic_tb
    import rtc_ctrl_pkg::*;
;
    logic       core_clk, rst_n, addr_wr_en, data_wr_en, data_rd_en;
    logic       osc_clk_in, osc_timeout, alarm_match, fail_at_reset;
    logic [7:0] wdata, addr_rdata, data_rdata, m_ctl, rd, v;
    logic       osc_enable, osc_bias_en, missing_osc_detect_en, timer_run;
    logic       alarm_enable, alarm_autoreset_en, timer_set_strobe;
    logic       timer_capture_strobe, timer_autoreset_strobe;
    int         n_errors, checks_done, seed, n_set, n_cap, n_ar;
    int         e_set, e_cap, e_ar, m_fail, m_alarm, m_set, m_cap, m_ar;

    rtc_control_register_logic u_rtc_control_register_logic (
        .core_clk(core_clk), .rst_n(rst_n), .addr_wr_en(addr_wr_en),
        .data_wr_en(data_wr_en), .data_rd_en(data_rd_en), .wdata(wdata),
        .addr_rdata(addr_rdata), .data_rdata(data_rdata),
        .osc_clk_in(osc_clk_in), .osc_timeout(osc_timeout),
        .alarm_match(alarm_match), .fail_at_reset(fail_at_reset),
        .osc_enable(osc_enable), .osc_bias_en(osc_bias_en),
        .missing_osc_detect_en(missing_osc_detect_en),
        .timer_run(timer_run), .alarm_enable(alarm_enable),
        .alarm_autoreset_en(alarm_autoreset_en),
        .timer_set_strobe(timer_set_strobe),
        .timer_capture_strobe(timer_capture_strobe),
        .timer_autoreset_strobe(timer_autoreset_strobe));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Strobe counters
    always @(posedge core_clk)
    begin
        if (timer_set_strobe === 1'b1) n_set <= n_set + 1;
        if (timer_capture_strobe === 1'b1) n_cap <= n_cap + 1;
        if (timer_autoreset_strobe === 1'b1) n_ar <= n_ar + 1;
    end

    task automatic wrap_up();
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_addr(input logic [7:0] d);
        @(posedge core_clk);
        addr_wr_en <= 1'b1;
        wdata      <= d;
        @(posedge core_clk);
        addr_wr_en <= 1'b0;
    endtask

    task automatic wr_data(input logic [7:0] d);
        @(posedge core_clk);
        data_wr_en <= 1'b1;
        wdata      <= d;
        @(posedge core_clk);
        data_wr_en <= 1'b0;
    endtask

    // Model image of the control register
    function automatic logic [7:0] img();
        return m_ctl | 8'(m_fail << 5) | 8'(m_alarm << 2) | 8'(m_set << 1)
            | 8'(m_cap);
    endfunction

    task automatic chk_outs();
        logic [7:0] e, g;
        @(negedge core_clk);
        e = {m_ctl[7], m_ctl[7], m_ctl[7] & m_ctl[6], m_ctl[4], m_ctl[3],
             m_ar[0], 2'b00};
        g = {osc_enable, osc_bias_en, missing_osc_detect_en, timer_run,
             alarm_enable, alarm_autoreset_en, 2'b00};
        chk("outs", e, g);
    endtask

    task automatic wr_ctl(input logic [7:0] d);
        wr_addr(8'h04);
        wr_data(d);
        m_ctl   = d & 8'hd8;
        m_ar    = d[2];
        m_alarm = 0;
        if (d[1]) m_set = 1;
        if (d[0]) m_cap = 1;
        if (!d[5]) m_fail = 0;
        chk_outs();
    endtask

    task automatic settle(input logic [7:0] a, input logic [7:0] e);
        int k;
        k = 0;
        while (addr_rdata[7] !== 1'b0 && k < 8)
        begin
            @(negedge core_clk);
            k++;
        end
        chk("addr_rdata", a & 8'h5f, addr_rdata);
        chk("data_rdata", e, data_rdata);
    endtask

    task automatic fetch(input logic [7:0] a, input logic [7:0] e);
        wr_addr(a | 8'h80);
        @(negedge core_clk);
        chk("busy", 8'h01, {7'h00, addr_rdata[7]});
        settle(a, e);
    endtask

    task automatic osc_edge();
        @(posedge core_clk);
        osc_clk_in <= 1'b1;
        repeat (6) @(posedge core_clk);
        osc_clk_in <= 1'b0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic pulse_in(input int which);
        @(posedge core_clk);
        if (which == 0) osc_timeout <= 1'b1;
        else alarm_match <= 1'b1;
        repeat (6) @(posedge core_clk);
        osc_timeout <= 1'b0;
        alarm_match <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        wrap_up();
    end

    initial
    begin
        {rst_n, addr_wr_en, data_wr_en, data_rd_en, wdata} = '0;
        {osc_clk_in, osc_timeout, alarm_match} = '0;
        fail_at_reset = 1'b1;
        seed = 32'hb79f;
        {n_errors, checks_done, n_set, n_cap, n_ar, e_set, e_cap, e_ar} = '0;
        {m_set, m_cap, m_alarm, m_ar, m_ctl} = '0;
        m_fail = 1;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk_outs();
        chk("addr_reset", 8'h00, addr_rdata);
        fetch(8'h04, img());
        wr_addr(8'h3f);
        @(negedge core_clk);
        chk("addr_mask", 8'h1f, addr_rdata);
        wr_ctl(8'h00);
        fetch(8'h04, img());
        repeat (6)
        begin
            v = 8'($random(seed)) & 8'hfc;
            wr_ctl(v);
            fetch(8'h04, img());
        end
        wr_addr(8'h05);
        wr_data(8'hff);
        chk_outs();
        fetch(8'h05, 8'h00);
        wr_ctl(8'h80);
        pulse_in(0);
        fetch(8'h04, img());
        wr_ctl(8'hc0);
        pulse_in(0);
        m_fail = 1;
        fetch(8'h04, img());
        wr_ctl(8'he0);
        fetch(8'h04, img());
        wr_ctl(8'hc0);
        fetch(8'h04, img());
        for (int i = 0; i < 2; i++)
        begin
            wr_ctl(8'h90 | 8'(1 << i));
            fetch(8'h04, img());
            chk("strobes", 8'(e_set + e_cap), 8'(n_set + n_cap));
            osc_edge();
            if (i == 0) e_cap++;
            else e_set++;
            {m_set, m_cap} = '0;
            chk("cap_cnt", 8'(e_cap), 8'(n_cap));
            chk("set_cnt", 8'(e_set), 8'(n_set));
            fetch(8'h04, img());
        end
        wr_ctl(8'h9c);
        pulse_in(1);
        m_alarm = 1;
        e_ar++;
        fetch(8'h04, img());
        chk_outs();
        chk("ar_cnt", 8'(e_ar), 8'(n_ar));
        osc_edge();
        m_alarm = 0;
        fetch(8'h04, img());
        pulse_in(1);
        e_ar++;
        wr_ctl(8'h98);
        fetch(8'h04, img());
        wr_ctl(8'h90);
        pulse_in(1);
        fetch(8'h04, img());
        chk("ar_cnt", 8'(e_ar), 8'(n_ar));
        fetch(8'h44, img());
        @(posedge core_clk);
        data_rd_en <= 1'b1;
        @(posedge core_clk);
        data_rd_en <= 1'b0;
        @(negedge core_clk);
        settle(8'h44, img());
        // Second reset, fail flag now comes up clear
        @(posedge core_clk);
        rst_n         <= 1'b0;
        fail_at_reset <= 1'b0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        {m_ctl, m_ar, m_fail} = '0;
        repeat (2) @(posedge core_clk);
        chk_outs();
        chk("addr_reset", 8'h00, addr_rdata);
        fetch(8'h04, img());
        wrap_up();
    end
endmodule // rtc_control_register_logic_tb
